// File: logic/tsc_ctrl.v
// sensing cycle sequencer, calibration requests and touch alert control
`timescale 1ns/100ps
`include "tsc_map.vh"

// Notes on behaviour
// - repeat input: touch held beyond hold time is hold
// - repeat input: touch up to hold time is plain
// - hold time is (code+1) times 35 ms
// - samples per channel are two to the code
// - samples back to back, ascending, then averaged
// - sample time 320 us doubled per code step
// - cycle period is (code+1) times 35 ms
// - sample enabled channels, then low-power wait
// - sampling stretches the cycle when too long
// - writing one requests calibration, zero nothing; the code loads the written bits, so a zero clears the request
// - calibration updates value, clears bit on success
// - failed calibration leaves bit, sets fail flag
// - newly enabled input gets its calibration bit
// - zero over pending bit may skip calibration
// - enabled input touch asserts the alert low
// - no repeat: alert on touch and release only
// - repeat plain touch: touch and optional release
// - repeat hold: touch, then every repeat interval
// - repeat interval is (code+1) times 35 ms
// - release mask bit suppresses release alert
module tsc_ctrl #(
   parameter [21:0] TICK_CYC = `TSC_TICK_CYC,
   parameter [19:0] SAMP_CYC = `TSC_SAMP_CYC
) (
   // clock and reset
   input  wire        core_clk_i,
   input  wire        resetn_i,
   // register port
   input  wire [7:0]  reg_addr_i,
   input  wire        reg_wr_i,
   input  wire [7:0]  reg_wdata_i,
   input  wire        reg_rd_i,
   output reg  [7:0]  reg_rdata_o,
   // configuration held elsewhere
   input  wire [2:0]  chan_en_i,
   input  wire        wake_i,
   input  wire        release_irq_mask_i,
   input  wire [3:0]  repeat_interval_sel_i,
   input  wire        cal_fail_clr_i,
   input  wire        alert_clr_i,
   // analog front end
   output reg  [1:0]  sense_ch_o,
   output reg         sample_start_o,
   input  wire [15:0] sample_data_i,
   output reg         cal_start_o,
   input  wire        cal_done_i,
   input  wire [9:0]  cal_value_i,
   input  wire        noise_i,
   output reg         lowpower_o,
   // results and status
   output reg  [15:0] meas_data_o,
   output reg  [1:0]  meas_ch_o,
   output reg         meas_valid_o,
   output reg  [9:0]  cal_value_o,
   output reg         cal_upd_o,
   output reg         analog_cal_fail_flag_o,
   input  wire [2:0]  touch_i,
   output reg         alert_n_o
);

   localparam [2:0] S_WAIT = 3'b001;
   localparam [2:0] S_CAL  = 3'b010;
   localparam [2:0] S_SAMP = 3'b100;

   reg        rst_s1_r;
   reg        rst_n_r;
   reg  [3:0] hold_sel_r;
   reg  [6:0] avg_cfg_r;
   reg  [2:0] cal_req_r;
   reg  [2:0] irq_en_r;
   reg  [2:0] rpt_en_r;
   reg  [2:0] en_prev_r;
   reg  [2:0] state_r;
   reg  [1:0] ch_r;
   reg        busy_r;
   reg  [19:0] stmr_r;
   reg  [6:0] nsamp_r;
   reg  [22:0] acc_r;
   reg  [21:0] cpre_r;
   reg  [2:0] ctk_r;
   reg  [21:0] tpre_r;
   reg  [2:0] touch_prev_r;
   reg  [2:0] cal_clr;
   wire [2:0] avg_sel = avg_cfg_r[`TSC_AVG_MSB:`TSC_AVG_LSB];
   wire [1:0] samp_sel = avg_cfg_r[`TSC_SAMP_MSB:`TSC_SAMP_LSB];
   wire [1:0] cyc_sel = avg_cfg_r[`TSC_CYC_MSB:`TSC_CYC_LSB];
   wire [19:0] samp_len = SAMP_CYC << samp_sel;
   wire [6:0] nlast = (7'h01 << avg_sel) - 7'h01;
   wire [22:0] acc_sum = acc_r + {7'h00, sample_data_i};
   wire [22:0] avg_val = acc_sum >> avg_sel;
   wire       tick = (tpre_r == TICK_CYC - 22'h000001);
   wire [2:0] new_en = chan_en_i & ~en_prev_r;
   wire       cal_ok = ~noise_i && (cal_value_i != `TSC_CAL_MIN)
                       && (cal_value_i != `TSC_CAL_MAX);
   wire [2:0] ev;

   // reset release through two flops
   always @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // per input hold and repeat timing, ticks of 35 ms
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_in
         reg [4:0] held_tk_r;
         reg [4:0] rpt_tk_r;
         wire      held = (held_tk_r > {1'b0, hold_sel_r} + 5'h01);
         wire      rise = touch_i[gi] & ~touch_prev_r[gi];
         wire      fall = ~touch_i[gi] & touch_prev_r[gi];
         wire      rpt_hit = tick & held & rpt_en_r[gi]
                   & (rpt_tk_r == {1'b0, repeat_interval_sel_i});
         // plain touch keeps its release alert, hold with repeat drops it
         wire      rel_ok = ~release_irq_mask_i
                   & ~(rpt_en_r[gi] & held);
         assign ev[gi] = irq_en_r[gi] & (rise | (fall & rel_ok) | rpt_hit);
         always @(posedge core_clk_i or negedge rst_n_r)
         begin
            if (!rst_n_r)
            begin
               held_tk_r <= 5'h00;
               rpt_tk_r  <= 5'h00;
            end
            else if (!touch_i[gi])
            begin
               if (!fall)
                  held_tk_r <= 5'h00;
               rpt_tk_r <= 5'h00;
            end
            else if (tick)
            begin
               if (held_tk_r != 5'h1F)
                  held_tk_r <= held_tk_r + 5'h01;
               // interval restarts at each repeat alert
               // counts only while held, so the first repeat lands code+1 ticks in
               rpt_tk_r <= (rpt_hit || !held) ? 5'h00 : rpt_tk_r + 5'h01;
            end
         end
      end
   endgenerate

   // register port
   always @(posedge core_clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         hold_sel_r  <= `TSC_RST_HOLD;
         avg_cfg_r   <= `TSC_RST_AVG;
         irq_en_r    <= `TSC_RST_IRQ_EN;
         rpt_en_r    <= `TSC_RST_RPT_EN;
         reg_rdata_o <= 8'h00;
      end
      else
      begin
         if (reg_wr_i)
         begin
            case (reg_addr_i)
               `TSC_ADDR_HOLD:   hold_sel_r <= reg_wdata_i[`TSC_HOLD_MSB:0];
               `TSC_ADDR_AVG:    avg_cfg_r  <= reg_wdata_i[`TSC_AVG_MSB:0];
               `TSC_ADDR_IRQ_EN: irq_en_r   <= reg_wdata_i[2:0];
               `TSC_ADDR_RPT_EN: rpt_en_r   <= reg_wdata_i[2:0];
               default:          ;
            endcase
         end
         if (reg_rd_i)
         begin
            case (reg_addr_i)
               `TSC_ADDR_HOLD:   reg_rdata_o <= {4'h0, hold_sel_r};
               `TSC_ADDR_AVG:    reg_rdata_o <= {1'b0, avg_cfg_r};
               `TSC_ADDR_CAL:    reg_rdata_o <= {5'h00, cal_req_r};
               `TSC_ADDR_IRQ_EN: reg_rdata_o <= {5'h00, irq_en_r};
               `TSC_ADDR_RPT_EN: reg_rdata_o <= {5'h00, rpt_en_r};
               default:          reg_rdata_o <= 8'h00;
            endcase
         end
      end
   end

   // calibration request bits; hardware set beats host clear
   always @(posedge core_clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         cal_req_r <= `TSC_RST_CAL;
         en_prev_r <= 3'h0;
      end
      else
      begin
         en_prev_r <= chan_en_i;
         if (reg_wr_i && reg_addr_i == `TSC_ADDR_CAL)
            cal_req_r <= reg_wdata_i[2:0]
                         | new_en | (wake_i ? chan_en_i : 3'h0);
         else
            cal_req_r <= (cal_req_r & ~cal_clr)
                         | new_en | (wake_i ? chan_en_i : 3'h0);
      end
   end

   // sensing cycle sequencer
   always @(posedge core_clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         state_r      <= S_WAIT;
         ch_r         <= 2'h0;
         busy_r       <= 1'b0;
         stmr_r       <= 20'h00000;
         nsamp_r      <= 7'h00;
         acc_r        <= 23'h000000;
         cpre_r       <= 22'h000000;
         ctk_r        <= 3'h0;
         tpre_r       <= 22'h000000;
         touch_prev_r <= 3'h0;
         cal_clr      <= 3'h0;
         sense_ch_o   <= 2'h0;
         sample_start_o <= 1'b0;
         cal_start_o  <= 1'b0;
         lowpower_o   <= 1'b0;
         meas_data_o  <= 16'h0000;
         meas_ch_o    <= 2'h0;
         meas_valid_o <= 1'b0;
         cal_value_o  <= 10'h000;
         cal_upd_o    <= 1'b0;
         analog_cal_fail_flag_o <= 1'b0;
         alert_n_o    <= 1'b1;
      end
      else
      begin
         sample_start_o <= 1'b0;
         cal_start_o  <= 1'b0;
         meas_valid_o <= 1'b0;
         cal_upd_o    <= 1'b0;
         cal_clr      <= 3'h0;
         touch_prev_r <= touch_i;
         tpre_r       <= tick ? 22'h000000 : tpre_r + 22'h000001;
         // alert stays low until cleared; a new event wins the clear
         if (|ev)
            alert_n_o <= 1'b0;
         else if (alert_clr_i)
            alert_n_o <= 1'b1;
         if (cal_fail_clr_i)
            analog_cal_fail_flag_o <= 1'b0;
         // cycle timer keeps running while sampling overruns
         if (cpre_r == TICK_CYC - 22'h000001)
         begin
            cpre_r <= 22'h000000;
            if (ctk_r != 3'h7)
               ctk_r <= ctk_r + 3'h1;
         end
         else
            cpre_r <= cpre_r + 22'h000001;
         sense_ch_o <= ch_r;
         case (state_r)
            S_WAIT:
            begin
               lowpower_o <= 1'b1;
               if (ctk_r > {1'b0, cyc_sel})
               begin
                  state_r    <= S_CAL;
                  ch_r       <= 2'h0;
                  cpre_r     <= 22'h000000;
                  ctk_r      <= 3'h0;
                  lowpower_o <= 1'b0;
               end
            end
            S_CAL:
            begin
               if (busy_r)
               begin
                  if (cal_done_i)
                  begin
                     busy_r      <= 1'b0;
                     cal_value_o <= cal_value_i;
                     cal_upd_o   <= 1'b1;
                     cal_clr     <= cal_ok ? (3'h1 << ch_r) : 3'h0;
                     // a failure in the clear cycle wins over the clear
                     if (!cal_ok)
                        analog_cal_fail_flag_o <= 1'b1;
                     ch_r <= ch_r + 2'h1;
                  end
               end
               else if (ch_r == 2'h3)
               begin
                  state_r <= S_SAMP;
                  ch_r    <= 2'h0;
               end
               else if (cal_req_r[ch_r] && chan_en_i[ch_r])
               begin
                  cal_start_o <= 1'b1;
                  busy_r      <= 1'b1;
               end
               else
                  ch_r <= ch_r + 2'h1;
            end
            S_SAMP:
            begin
               if (ch_r == 2'h3)
                  state_r <= S_WAIT;
               else if (!chan_en_i[ch_r] && !busy_r)
                  ch_r <= ch_r + 2'h1;
               else if (!busy_r)
               begin
                  sample_start_o <= 1'b1;
                  busy_r         <= 1'b1;
                  stmr_r         <= samp_len - 20'h00001;
               end
               else if (stmr_r != 20'h00000)
                  stmr_r <= stmr_r - 20'h00001;
               else
               begin
                  busy_r <= 1'b0;
                  if (nsamp_r == nlast)
                  begin
                     meas_data_o  <= avg_val[15:0];
                     meas_ch_o    <= ch_r;
                     meas_valid_o <= 1'b1;
                     acc_r        <= 23'h000000;
                     nsamp_r      <= 7'h00;
                     ch_r         <= ch_r + 2'h1;
                  end
                  else
                  begin
                     acc_r   <= acc_sum;
                     nsamp_r <= nsamp_r + 7'h01;
                  end
               end
            end
            default:
               state_r <= S_WAIT;
         endcase
      end
   end

endmodule // tsc_ctrl

// File: common/tsc_map.vh
// register map, field positions, reset values and timing constants of the touch controller
`ifndef TSC_MAP_VH
`define TSC_MAP_VH
`define TSC_ADDR_HOLD      8'h23
`define TSC_ADDR_AVG       8'h24
`define TSC_ADDR_CAL       8'h26
`define TSC_ADDR_IRQ_EN    8'h27
`define TSC_ADDR_RPT_EN    8'h28
`define TSC_RST_HOLD       4'h7
`define TSC_RST_AVG        7'h39
`define TSC_RST_CAL        3'h0
`define TSC_RST_IRQ_EN     3'h7
`define TSC_RST_RPT_EN     3'h7
`define TSC_HOLD_MSB       3
`define TSC_AVG_MSB        6
`define TSC_AVG_LSB        4
`define TSC_SAMP_MSB       3
`define TSC_SAMP_LSB       2
`define TSC_CYC_MSB        1
`define TSC_CYC_LSB        0
`define TSC_CLK_MHZ        100
`define TSC_TICK_MS        35
`define TSC_TICK_CYC       (`TSC_TICK_MS * 1000 * `TSC_CLK_MHZ)
`define TSC_SAMP_US        320
`define TSC_SAMP_CYC       (`TSC_SAMP_US * `TSC_CLK_MHZ)
`define TSC_CAL_MIN        10'h000
`define TSC_CAL_MAX        10'h3FF
`endif

// File: tb/tsc_ctrl_props.sv
// assertion checker for the touch sensing controller
`timescale 1ns/100ps
module tsc_ctrl_props (
   // clock and reset
   input wire       core_clk_i,
   input wire       resetn_i,
   // sensing and calibration
   input wire [1:0] sense_ch_o,
   input wire       sample_start_o,
   input wire       cal_done_i,
   input wire [9:0] cal_value_i,
   input wire       noise_i,
   input wire       lowpower_o,
   input wire [1:0] meas_ch_o,
   input wire       meas_valid_o,
   input wire [9:0] cal_value_o,
   input wire       cal_upd_o,
   // status and alert
   input wire       analog_cal_fail_flag_o,
   input wire       cal_fail_clr_i,
   input wire       alert_clr_i,
   input wire       alert_n_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   samp_awake_a: assert property (sample_start_o |-> !lowpower_o && sense_ch_o != 2'h3)
      else $error("sample started while idle");
   samp_gap_a: assert property (sample_start_o |=> !sample_start_o [*4])
      else $error("sample too short");
   meas_chan_a: assert property (meas_valid_o |-> meas_ch_o != 2'h3)
      else $error("result for no channel");
   cal_update_a: assert property (cal_done_i |=> cal_upd_o && cal_value_o == $past(cal_value_i))
      else $error("calibration value not updated");
   cal_fail_a: assert property (cal_done_i && (noise_i || cal_value_i == 10'h000
      || cal_value_i == 10'h3FF) |=> analog_cal_fail_flag_o) else $error("failure not flagged");
   fail_sticky_a: assert property (analog_cal_fail_flag_o && !cal_fail_clr_i |=> analog_cal_fail_flag_o)
      else $error("failure flag dropped");
   alert_sticky_a: assert property (!alert_n_o && !alert_clr_i |=> !alert_n_o)
      else $error("alert released early");
   calval_hold_a: assert property (!cal_upd_o |-> $stable(cal_value_o))
      else $error("calibration value moved");
endmodule // tsc_ctrl_props

bind tsc_ctrl tsc_ctrl_props props_u (.core_clk_i, .resetn_i, .sense_ch_o, .sample_start_o,
   .cal_done_i, .cal_value_i, .noise_i, .lowpower_o, .meas_ch_o, .meas_valid_o, .cal_value_o,
   .cal_upd_o, .analog_cal_fail_flag_o, .cal_fail_clr_i, .alert_clr_i, .alert_n_o);

// File: tb/tsc_afe_model.sv
// analog front end model: sample values and calibration answers
`timescale 1ns/100ps
module tsc_afe_model #(
   parameter CAL_LAT = 6
) (
   // from the controller
   input  wire        core_clk_i,
   input  wire [1:0]  sense_ch_o,
   input  wire        sample_start_o,
   input  wire        cal_start_o,
   // result chosen by the bench
   input  wire [9:0]  cal_res_i,
   input  wire        noise_res_i,
   // to the controller
   output reg  [15:0] sample_data_o = 16'h0000,
   output reg         cal_done_o = 1'b0,
   output reg  [9:0]  cal_value_o = 10'h000,
   output reg         noise_o = 1'b0
);
   reg [1:0] last_ch = 2'h0;
   reg       flip = 1'b0;
   integer   wait_n = 0;
   always @(posedge core_clk_i)
   begin
      // outside a result the lines show garbage, not the last answer
      cal_done_o <= 1'b0;
      cal_value_o <= ~cal_res_i;
      noise_o <= !noise_res_i;
      if (sample_start_o)
      begin
         // alternate +0/+2 so an even-count average lands on base+1
         flip = (sense_ch_o == last_ch) ? !flip : 1'b0;
         last_ch = sense_ch_o;
         sample_data_o <= {2'h0, sense_ch_o + 2'h1, 12'h010} + (flip ? 16'h0002 : 16'h0000);
      end
      if (wait_n == 1)
      begin
         cal_done_o <= 1'b1;
         cal_value_o <= cal_res_i;
         noise_o <= noise_res_i;
      end
      wait_n = cal_start_o ? CAL_LAT : (wait_n > 0 ? wait_n - 1 : 0);
   end
endmodule // tsc_afe_model

// File: tb/test_tsc_ctrl.sv
// self-checking bench for the touch controller
`timescale 1ns/100ps
module test_tsc_ctrl;
   reg        core_clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, wake_i = 0;
   reg        release_irq_mask_i = 0, cal_fail_clr_i = 0, alert_clr_i = 0, noise_res = 0;
   reg  [7:0] reg_addr_i = 0, reg_wdata_i = 0;
   reg  [2:0] chan_en_i = 0, touch_i = 0;
   reg  [3:0] repeat_interval_sel_i = 0;
   reg  [9:0] cal_res = 10'h155;
   reg  [1:0] sel = 0;
   wire [7:0] reg_rdata_o;
   wire [1:0] sense_ch_o, meas_ch_o;
   wire [15:0] sample_data_i, meas_data_o;
   wire [9:0] cal_value_i, cal_value_o;
   wire       sample_start_o, cal_start_o, cal_done_i, noise_i, lowpower_o, meas_valid_o;
   wire       cal_upd_o, analog_cal_fail_flag_o, alert_n_o;
   wire       evt = (sel == 2'h0) ? cal_upd_o : (sel == 2'h1) ? meas_valid_o : lowpower_o;
   integer    failures = 0, n_compared = 0, i;
   reg [23:0] rows [0:9];
   always #5 core_clk_i = !core_clk_i;
   tsc_ctrl #(.TICK_CYC(22'd100), .SAMP_CYC(20'd8)) dut_u (.core_clk_i, .resetn_i, .reg_addr_i,
      .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .chan_en_i, .wake_i, .release_irq_mask_i,
      .repeat_interval_sel_i, .cal_fail_clr_i, .alert_clr_i, .sense_ch_o, .sample_start_o,
      .sample_data_i, .cal_start_o, .cal_done_i, .cal_value_i, .noise_i, .lowpower_o,
      .meas_data_o, .meas_ch_o, .meas_valid_o, .cal_value_o, .cal_upd_o,
      .analog_cal_fail_flag_o, .touch_i, .alert_n_o);
   tsc_afe_model afe_u (.core_clk_i, .sense_ch_o, .sample_start_o, .cal_start_o,
      .cal_res_i(cal_res), .noise_res_i(noise_res), .sample_data_o(sample_data_i),
      .cal_done_o(cal_done_i), .cal_value_o(cal_value_i), .noise_o(noise_i));
   task tick(input integer n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp)
         begin
            failures = failures + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         tick(1);
         reg_addr_i = a;
         reg_wdata_i = d;
         reg_wr_i = 1;
         tick(1);
         reg_wr_i = 0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         tick(1);
         reg_addr_i = a;
         reg_rd_i = 1;
         tick(1);
         reg_rd_i = 0;
         chk({8'h00, reg_rdata_o}, {8'h00, e});
      end
   endtask
   // bounded wait; a miss is counted through chk
   task wait_evt(input [1:0] s);
      integer n;
      begin
         sel = s;
         n = 0;
         tick(1);
         while (evt !== 1'b1 && n < 5000)
         begin
            tick(1);
            n = n + 1;
         end
         chk({15'h0000, evt}, 16'h0001);
      end
   endtask
   task aclr;
      begin
         alert_clr_i = 1;
         tick(1);
         alert_clr_i = 0;
      end
   endtask
   task wrap_up;
      begin
         $display("compared %0d failures %0d", n_compared, failures);
         if (failures == 0 && n_compared > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial
   begin
      #900000;
      failures = failures + 1;
      wrap_up;
   end
   initial
   begin
      // address, write data, read back; first five rows are reset reads
      rows[0] = 24'h230007; rows[1] = 24'h240039; rows[2] = 24'h260000;
      rows[3] = 24'h270007; rows[4] = 24'h280007; rows[5] = 24'h23FF0F;
      rows[6] = 24'h24FF7F; rows[7] = 24'h27F800; rows[8] = 24'h28FA02;
      rows[9] = 24'h25FF00;
      tick(3);
      resetn_i = 1;
      tick(3);
      for (i = 0; i < 10; i = i + 1)
      begin
         if (i > 4)
            wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      wr(8'h24, 8'h10);
      wr(8'h27, 8'h07);
      wr(8'h28, 8'h00);
      wr(8'h23, 8'h00);
      chan_en_i = 3'h1;
      wait_evt(2'h0);
      chk({6'h00, cal_value_o}, 16'h0155);
      tick(2);
      rd(8'h26, 8'h00);
      cal_res = 10'h3FF;
      wr(8'h26, 8'h01);
      wait_evt(2'h0);
      chk({15'h0000, analog_cal_fail_flag_o}, 16'h0001);
      rd(8'h26, 8'h01);
      cal_res = 10'h155;
      wr(8'h26, 8'h00);
      rd(8'h26, 8'h00);
      cal_fail_clr_i = 1;
      tick(1);
      cal_fail_clr_i = 0;
      chk({15'h0000, analog_cal_fail_flag_o}, 16'h0000);
      chan_en_i = 3'h3;
      wait_evt(2'h2);
      for (i = 0; i < 2; i = i + 1)
      begin
         wait_evt(2'h1);
         chk({meas_ch_o, meas_data_o[13:0]}, {i[1:0], i[1:0] + 2'h1, 12'h011});
      end
      wr(8'h27, 8'h06);
      aclr;
      touch_i = 3'h1;
      tick(3);
      chk({15'h0000, alert_n_o}, 16'h0001);
      touch_i = 3'h0;
      wr(8'h27, 8'h07);
      aclr;
      touch_i = 3'h2;
      tick(2);
      chk({15'h0000, alert_n_o}, 16'h0000);
      aclr;
      tick(500);
      chk({15'h0000, alert_n_o}, 16'h0001);
      touch_i = 3'h0;
      tick(2);
      chk({15'h0000, alert_n_o}, 16'h0000);
      release_irq_mask_i = 1;
      touch_i = 3'h2;
      tick(2);
      aclr;
      touch_i = 3'h0;
      tick(2);
      chk({15'h0000, alert_n_o}, 16'h0001);
      release_irq_mask_i = 0;
      wr(8'h28, 8'h07);
      touch_i = 3'h4;
      tick(2);
      aclr;
      tick(400);
      chk({15'h0000, alert_n_o}, 16'h0000);
      aclr;
      touch_i = 3'h0;
      tick(2);
      chk({15'h0000, alert_n_o}, 16'h0001);
      touch_i = 3'h4;
      tick(20);
      aclr;
      touch_i = 3'h0;
      tick(2);
      chk({15'h0000, alert_n_o}, 16'h0000);
      resetn_i = 0;
      tick(3);
      resetn_i = 1;
      tick(3);
      rd(8'h24, 8'h39);
      wrap_up;
   end
endmodule // test_tsc_ctrl
